// *** rtl/clock_tree.sv ***
// Derives the ADC and pixel clocks from the crystal clock by a binary counter.
// Assumes sys_clk is the undivided crystal clock.
`timescale 1ns/10ps
`default_nettype none
module clock_tree (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] divisor,
  input wire logic four_bit_mode,
  output logic adc_clk,
  output logic pixel_clk
);

  logic [exposure_pkg::CLK_CNT_W-1:0] cnt_r;
  logic adc_clk_r;
  logic pixel_clk_r;
  wire [2:0] adc_tap;
  wire [2:0] pix_tap;

  // Tap n gives half, quarter, eighth or sixteenth rate
  assign adc_tap = {1'b0, divisor};
  // Pixel sits two or three taps above the ADC clock
  assign pix_tap = adc_tap + (four_bit_mode ? exposure_pkg::PIX_RATIO_4BIT
                                            : exposure_pkg::PIX_RATIO_8BIT);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      adc_clk_r <= 1'b0;
      pixel_clk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      adc_clk_r <= cnt_r[adc_tap]; // see RULE_06
      pixel_clk_r <= cnt_r[pix_tap]; // see RULE_04 see RULE_07
    end
  end

  assign adc_clk = adc_clk_r;
  assign pixel_clk = pixel_clk_r;

endmodule
`default_nettype wire

// *** rtl/exposure_pkg.sv ***
// Shared constants and types for the exposure register bank and its two-wire slave.
// Assumes a single crystal-rate clock; all indices are 7-bit register numbers.
package exposure_pkg;

  ////////////////////////////////////////
  // Register indices
  localparam logic [6:0] IDX_GAIN = 7'h24;
  localparam logic [6:0] IDX_DIVISOR = 7'h25;
  localparam logic [6:0] IDX_GAIN_CEIL = 7'h26;
  localparam logic [6:0] IDX_THR_LOW = 7'h27;
  localparam logic [6:0] IDX_THR_MID = 7'h28;
  localparam logic [6:0] IDX_THR_HIGH = 7'h29;
  localparam logic [6:0] IDX_FRAME_AVG = 7'h73;
  localparam logic [6:0] IDX_CMP_THR = 7'h75;

  ////////////////////////////////////////
  // Reset values
  localparam logic [2:0] RST_GAIN = 3'h0;
  localparam logic [1:0] RST_DIVISOR = 2'h0;
  localparam logic [2:0] RST_GAIN_CEIL = 3'h7;
  localparam logic [7:0] RST_THR_LOW = 8'h55;
  localparam logic [7:0] RST_THR_MID = 8'h64;
  localparam logic [7:0] RST_THR_HIGH = 8'h73;
  localparam logic [7:0] RST_FRAME_AVG = 8'h00;
  localparam logic [7:0] RST_CMP_THR = 8'h80;

  ////////////////////////////////////////
  // Index byte and slave address layout
  localparam int AUTO_INC_BIT = 7;
  localparam logic [6:0] SLAVE_BASE = 7'h10;
  localparam int SEL0_BIT = 0;
  localparam int SEL1_BIT = 1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  ////////////////////////////////////////
  // Gain thermometer codes and comparator levels
  localparam logic [2:0] THERM_0 = 3'h0;
  localparam logic [2:0] THERM_1 = 3'h1;
  localparam logic [2:0] THERM_2 = 3'h3;
  localparam logic [2:0] THERM_3 = 3'h7;
  localparam logic [7:0] FULL_8 = 8'hE0;
  localparam logic [7:0] BLACK_8 = 8'h10;
  localparam logic [3:0] FULL_4 = 4'hE;
  localparam logic [3:0] BLACK_4 = 4'h1;

  ////////////////////////////////////////
  // Clock tree
  localparam int CLK_CNT_W = 7;
  localparam logic [2:0] PIX_RATIO_4BIT = 3'h2;
  localparam logic [2:0] PIX_RATIO_8BIT = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_INDEX = 3'b010,
    ST_WDATA = 3'b011,
    ST_ACK = 3'b100,
    ST_READ = 3'b101,
    ST_RACK = 3'b110,
    ST_RNEXT = 3'b111
  } link_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } link_evt_t;

  // Gain in thousandths, non-linear in the code
  function automatic logic [13:0] gain_milli(input logic [2:0] code);
    logic [13:0] g;
    g = 14'h03E8;
    case (code)
      3'h0: g = 14'h03E8;
      3'h1: g = 14'h07D0;
      3'h2: g = 14'h0535;
      3'h3: g = 14'h0FA0;
      3'h4: g = 14'h0477;
      3'h5: g = 14'h0A6B;
      3'h6: g = 14'h0640;
      3'h7: g = 14'h1F40;
      default: g = 14'h03E8;
    endcase
    return g;
  endfunction

endpackage

// *** rtl/exposure_regs.sv ***
// Exposure register bank, two-wire slave, gain stepping and decoding,
// clock tree and ADC threshold comparator.
// Assumes sys_clk is the crystal clock and all pins are synchronous to it.
//
// Behaviour
// RULE_01 - Any gain code may be written; auto gain picks thermometer codes
// RULE_02 - Gain codes decode non-linearly, 1.000 to 8.000
// RULE_03 - Lowering from code 110 gives 011
// RULE_04 - Two-bit divisor, reset zero, sets the clock division
// RULE_05 - Clock generator, slave and registers use the crystal clock
// RULE_06 - ADC clock is crystal over two; code then divides by 1, 2, 4 or 8 (divisor 0 to 3)
// RULE_07 - Pixel clock is ADC clock over 4 in 4-bit mode, else 8
// RULE_08 - Three exposure thresholds reset to 85, 100 and 115
// RULE_09 - Frame-average register, reset zero, injects a synthetic average
// RULE_10 - Comparator maps results at or above threshold to full scale
// RULE_11 - Comparator maps results below threshold to black level
// RULE_12 - Disabled comparator passes ADC results unchanged
// RULE_13 - Threshold resets to 128; 4-bit mode compares its upper nibble
// RULE_14 - Messages carry zero or more data bytes; zero only loads the index
// RULE_15 - Address 0010000 write, 0010001 read; select inputs set low bits
// RULE_16 - Index holds after each data byte without auto-increment
// RULE_17 - Index is kept after a write for a later read
// RULE_18 - Master ends every read with a negative acknowledge
// RULE_19 - Master sets index by empty write, repeated start, then read
// RULE_20 - Without auto-increment, write bytes all land in one register
// RULE_21 - Index byte msb enables auto-increment across adjacent registers
// RULE_22 - Without auto-increment, acknowledged reads repeat one register
// RULE_23 - Automatic gain never rises above the gain ceiling
`timescale 1ns/10ps
`default_nettype none
module exposure_regs (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic address_select_0,
  input wire logic address_select_1,
  input wire logic agc_enable,
  input wire logic agc_lower,
  input wire logic agc_raise,
  input wire logic comparator_enable,
  input wire logic four_bit_mode,
  input wire logic adc_valid,
  input wire logic [7:0] adc_data,
  output logic [7:0] adc_out,
  output logic adc_out_valid,
  output logic [2:0] gain_code,
  output logic [13:0] gain_value_milli,
  output logic [1:0] divisor,
  output logic [2:0] gain_ceiling,
  output logic [7:0] threshold_low,
  output logic [7:0] threshold_mid,
  output logic [7:0] threshold_high,
  output logic [7:0] forced_frame_average,
  output logic forced_average_load,
  output logic [7:0] compare_threshold,
  output logic adc_clk,
  output logic pixel_clk
);

  ////////////////////////////////////////
  // Link events and protocol state

  exposure_pkg::link_evt_t evt;
  exposure_pkg::link_state_t state_r;
  exposure_pkg::link_state_t ack_next_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] index_r;
  logic auto_inc_r;
  logic sda_oe_n_r;
  logic sda_out_r;
  logic wr_stb_r;
  logic [6:0] wr_idx_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data;

  two_wire_edges u_edges (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .evt(evt)
  );

  wire [6:0] own_addr = {exposure_pkg::SLAVE_BASE[6:2], address_select_1, address_select_0}; // see RULE_15
  wire [7:0] rx_byte = shift_r;
  wire byte_done = evt.fall && (bit_cnt_r == exposure_pkg::BITS_PER_BYTE);
  wire addr_hit = (rx_byte[7:1] == own_addr);
  wire rx_is_read = rx_byte[0];
  // Index moves only with auto-increment
  wire [6:0] index_step = auto_inc_r ? 7'(index_r + 7'h01) : index_r; // see RULE_16 see RULE_21

  ////////////////////////////////////////
  // Serial engine: sample on scl rise, drive after scl fall

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= exposure_pkg::ST_IDLE;
      ack_next_r <= exposure_pkg::ST_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      index_r <= 7'h00;
      auto_inc_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      wr_stb_r <= 1'b0;
      wr_idx_r <= 7'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (evt.start) begin
        state_r <= exposure_pkg::ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_n_r <= 1'b1;
      end else if (evt.stop) begin
        state_r <= exposure_pkg::ST_IDLE;
        sda_oe_n_r <= 1'b1;
      end else begin
        unique case (state_r)
          exposure_pkg::ST_IDLE: begin
            sda_oe_n_r <= 1'b1;
          end
          exposure_pkg::ST_ADDR, exposure_pkg::ST_INDEX, exposure_pkg::ST_WDATA: begin
            if (evt.rise) begin
              shift_r <= {shift_r[6:0], evt.sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (byte_done) begin
              bit_cnt_r <= 4'h0;
              if (state_r == exposure_pkg::ST_ADDR) begin
                if (addr_hit) begin
                  sda_oe_n_r <= 1'b0;
                  state_r <= exposure_pkg::ST_ACK;
                  ack_next_r <= rx_is_read ? exposure_pkg::ST_READ : exposure_pkg::ST_INDEX;
                end else begin
                  state_r <= exposure_pkg::ST_IDLE;
                end
              end else if (state_r == exposure_pkg::ST_INDEX) begin
                // An index byte alone only sets the index
                index_r <= rx_byte[6:0]; // see RULE_14 see RULE_19
                auto_inc_r <= rx_byte[exposure_pkg::AUTO_INC_BIT]; // see RULE_21
                sda_oe_n_r <= 1'b0;
                state_r <= exposure_pkg::ST_ACK;
                ack_next_r <= exposure_pkg::ST_WDATA;
              end else begin
                wr_stb_r <= 1'b1; // see RULE_20
                wr_idx_r <= index_r;
                wr_data_r <= rx_byte;
                // Index survives the write for later reads
                index_r <= index_step; // see RULE_16 see RULE_17
                sda_oe_n_r <= 1'b0;
                state_r <= exposure_pkg::ST_ACK;
                ack_next_r <= exposure_pkg::ST_WDATA;
              end
            end
          end
          exposure_pkg::ST_ACK: begin
            if (evt.fall) begin
              state_r <= ack_next_r;
              if (ack_next_r == exposure_pkg::ST_READ) begin
                shift_r <= rd_data;
                sda_oe_n_r <= rd_data[7];
                bit_cnt_r <= 4'h1;
              end else begin
                sda_oe_n_r <= 1'b1;
                bit_cnt_r <= 4'h0;
              end
            end
          end
          exposure_pkg::ST_READ: begin
            if (evt.fall) begin
              if (bit_cnt_r == exposure_pkg::BITS_PER_BYTE) begin
                sda_oe_n_r <= 1'b1;
                state_r <= exposure_pkg::ST_RACK;
              end else begin
                sda_oe_n_r <= shift_r[6];
                shift_r <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          exposure_pkg::ST_RACK: begin
            if (evt.rise) begin
              // A negative acknowledge closes the read
              if (evt.sda) begin
                state_r <= exposure_pkg::ST_IDLE; // see RULE_18
              end else begin
                index_r <= index_step; // see RULE_22
                state_r <= exposure_pkg::ST_RNEXT;
              end
            end
          end
          exposure_pkg::ST_RNEXT: begin
            if (evt.fall) begin
              shift_r <= rd_data; // see RULE_22
              sda_oe_n_r <= rd_data[7];
              bit_cnt_r <= 4'h1;
              state_r <= exposure_pkg::ST_READ;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////
  // Register bank

  logic [2:0] gain_r;
  logic [1:0] divisor_r;
  logic [2:0] gain_ceil_r;
  logic [7:0] thr_low_r;
  logic [7:0] thr_mid_r;
  logic [7:0] thr_high_r;
  logic [7:0] frame_avg_r;
  logic [7:0] cmp_thr_r;
  logic avg_load_r;
  logic [13:0] gain_milli_r;

  function automatic logic [2:0] therm_down(input logic [2:0] c);
    logic [2:0] r;
    r = exposure_pkg::THERM_0;
    if (c > exposure_pkg::THERM_2) begin
      r = exposure_pkg::THERM_2;
    end else if (c > exposure_pkg::THERM_1) begin
      r = exposure_pkg::THERM_1;
    end
    return r;
  endfunction

  function automatic logic [2:0] therm_up(input logic [2:0] c);
    logic [2:0] r;
    r = exposure_pkg::THERM_3;
    if (c < exposure_pkg::THERM_1) begin
      r = exposure_pkg::THERM_1;
    end else if (c < exposure_pkg::THERM_2) begin
      r = exposure_pkg::THERM_2;
    end
    return r;
  endfunction

  wire wr_gain = wr_stb_r && (wr_idx_r == exposure_pkg::IDX_GAIN);
  // Steps land on thermometer codes, even from written ones
  wire [2:0] gain_lowered = therm_down(gain_r); // see RULE_01 see RULE_03
  wire [2:0] gain_raised = therm_up(gain_r); // see RULE_01
  // A raise that would pass the ceiling leaves the gain where it is
  wire raise_ok = gain_raised <= gain_ceil_r; // see RULE_23
  wire [2:0] gain_nxt = wr_gain ? wr_data_r[2:0] : // see RULE_01
                        (agc_enable && agc_lower) ? gain_lowered :
                        (agc_enable && agc_raise && raise_ok) ? gain_raised : gain_r;

  // Clock generator, slave and bank share the crystal clock
  always_ff @(posedge sys_clk or negedge reset_n) begin // see RULE_05
    if (!reset_n) begin
      gain_r <= exposure_pkg::RST_GAIN;
      divisor_r <= exposure_pkg::RST_DIVISOR;
      gain_ceil_r <= exposure_pkg::RST_GAIN_CEIL;
      thr_low_r <= exposure_pkg::RST_THR_LOW;
      thr_mid_r <= exposure_pkg::RST_THR_MID;
      thr_high_r <= exposure_pkg::RST_THR_HIGH;
      frame_avg_r <= exposure_pkg::RST_FRAME_AVG;
      cmp_thr_r <= exposure_pkg::RST_CMP_THR;
      avg_load_r <= 1'b0;
      gain_milli_r <= 14'h03E8;
    end else begin
      gain_r <= gain_nxt;
      gain_milli_r <= exposure_pkg::gain_milli(gain_r); // see RULE_02
      avg_load_r <= wr_stb_r && (wr_idx_r == exposure_pkg::IDX_FRAME_AVG); // see RULE_09
      if (wr_stb_r) begin
        case (wr_idx_r)
          exposure_pkg::IDX_DIVISOR: divisor_r <= wr_data_r[1:0]; // see RULE_04
          exposure_pkg::IDX_GAIN_CEIL: gain_ceil_r <= wr_data_r[2:0];
          exposure_pkg::IDX_THR_LOW: thr_low_r <= wr_data_r; // see RULE_08
          exposure_pkg::IDX_THR_MID: thr_mid_r <= wr_data_r; // see RULE_08
          exposure_pkg::IDX_THR_HIGH: thr_high_r <= wr_data_r; // see RULE_08
          exposure_pkg::IDX_FRAME_AVG: frame_avg_r <= wr_data_r; // see RULE_09
          exposure_pkg::IDX_CMP_THR: cmp_thr_r <= wr_data_r; // see RULE_13
          default: ;
        endcase
      end
    end
  end

  // Unmapped indices read as zero; narrow fields pad with zeros above
  always_comb begin
    rd_data = 8'h00;
    case (index_r)
      exposure_pkg::IDX_GAIN: rd_data = {5'h00, gain_r};
      exposure_pkg::IDX_DIVISOR: rd_data = {6'h00, divisor_r};
      exposure_pkg::IDX_GAIN_CEIL: rd_data = {5'h00, gain_ceil_r};
      exposure_pkg::IDX_THR_LOW: rd_data = thr_low_r;
      exposure_pkg::IDX_THR_MID: rd_data = thr_mid_r;
      exposure_pkg::IDX_THR_HIGH: rd_data = thr_high_r;
      exposure_pkg::IDX_FRAME_AVG: rd_data = frame_avg_r;
      exposure_pkg::IDX_CMP_THR: rd_data = cmp_thr_r;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////
  // Digital threshold comparator

  logic [7:0] adc_out_r;
  logic adc_out_valid_r;

  // 4-bit mode compares the low nibble against the threshold's upper nibble
  wire hit_8 = adc_data >= cmp_thr_r;
  wire hit_4 = adc_data[3:0] >= cmp_thr_r[7:4]; // see RULE_13
  wire [7:0] level_8 = hit_8 ? exposure_pkg::FULL_8 : exposure_pkg::BLACK_8; // see RULE_10 see RULE_11
  wire [7:0] level_4 = {4'h0, hit_4 ? exposure_pkg::FULL_4 : exposure_pkg::BLACK_4}; // see RULE_10 see RULE_11
  wire [7:0] cmp_out = four_bit_mode ? level_4 : level_8;
  wire [7:0] adc_nxt = comparator_enable ? cmp_out : adc_data; // see RULE_12

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_out_r <= 8'h00;
      adc_out_valid_r <= 1'b0;
      sda_out_r <= 1'b0;
    end else begin
      adc_out_valid_r <= adc_valid;
      sda_out_r <= 1'b0;
      if (adc_valid) begin
        adc_out_r <= adc_nxt;
      end
    end
  end

  ////////////////////////////////////////
  // Clocks and outputs

  clock_tree u_clocks (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .divisor(divisor_r),
    .four_bit_mode(four_bit_mode),
    .adc_clk(adc_clk),
    .pixel_clk(pixel_clk)
  );

  // Open drain: only ever pulls low
  assign sda_out = sda_out_r;
  assign sda_oe_n = sda_oe_n_r;
  assign adc_out = adc_out_r;
  assign adc_out_valid = adc_out_valid_r;
  assign gain_code = gain_r;
  assign gain_value_milli = gain_milli_r;
  assign divisor = divisor_r;
  assign gain_ceiling = gain_ceil_r;
  assign threshold_low = thr_low_r;
  assign threshold_mid = thr_mid_r;
  assign threshold_high = thr_high_r;
  assign forced_frame_average = frame_avg_r;
  assign forced_average_load = avg_load_r;
  assign compare_threshold = cmp_thr_r;

endmodule
`default_nettype wire

// *** rtl/two_wire_edges.sv ***
// Turns sampled serial clock and data levels into start, stop and clock edge events.
// Assumes scl and sda are already synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module two_wire_edges (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output exposure_pkg::link_evt_t evt
);

  logic scl_q_r;
  logic sda_q_r;
  exposure_pkg::link_evt_t evt_r;
  exposure_pkg::link_evt_t evt_nxt;

  // Bus idles high, so the previous levels reset high
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      evt_r <= '0;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      evt_r <= evt_nxt;
    end
  end

  assign evt_nxt.start = scl_q_r & scl_in & sda_q_r & ~sda_in;
  assign evt_nxt.stop = scl_q_r & scl_in & ~sda_q_r & sda_in;
  assign evt_nxt.rise = scl_in & ~scl_q_r;
  assign evt_nxt.fall = ~scl_in & scl_q_r;
  assign evt_nxt.sda = sda_in;
  assign evt = evt_r;

endmodule
`default_nettype wire

// *** test/exposure_regs_asserts.sv ***
// Concurrent checks on the exposure register bank ports.
// Bound onto exposure_regs from the bench top; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module exposure_regs_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic agc_enable,
  input wire logic agc_lower,
  input wire logic agc_raise,
  input wire logic comparator_enable,
  input wire logic four_bit_mode,
  input wire logic adc_valid,
  input wire logic [7:0] adc_data,
  input wire logic [7:0] adc_out,
  input wire logic adc_out_valid,
  input wire logic [2:0] gain_code,
  input wire logic [13:0] gain_value_milli,
  input wire logic [2:0] gain_ceiling,
  input wire logic [7:0] compare_threshold,
  input wire logic [1:0] divisor,
  input wire logic adc_clk
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  localparam logic [13:0] GV [8] = '{14'h03E8, 14'h07D0, 14'h0535, 14'h0FA0, 14'h0477, 14'h0A6B, 14'h0640, 14'h1F40};
  ////////////////////////////////////////
  property p_full;
    comparator_enable && !four_bit_mode && adc_valid && adc_data >= compare_threshold |=> adc_out == 8'hE0;
  endproperty
  a_full: assert property (p_full) else $error("no full scale");
  property p_black;
    comparator_enable && !four_bit_mode && adc_valid && adc_data < compare_threshold |=> adc_out == 8'h10;
  endproperty
  a_black: assert property (p_black) else $error("no black level");
  property p_pass;
    !comparator_enable && adc_valid |=> adc_out == $past(adc_data) && adc_out_valid;
  endproperty
  a_pass: assert property (p_pass) else $error("bypass altered");
  property p_four;
    comparator_enable && four_bit_mode && adc_valid && adc_data[3:0] >= compare_threshold[7:4] |=> adc_out == 8'h0E;
  endproperty
  a_four: assert property (p_four) else $error("nibble compare");
  property p_dec;
    1'b1 |=> gain_value_milli == GV[$past(gain_code)];
  endproperty
  a_dec: assert property (p_dec) else $error("gain decode");
  property p_therm;
    agc_enable && agc_lower |=> gain_code inside {3'h0, 3'h1, 3'h3, 3'h7};
  endproperty
  a_therm: assert property (p_therm) else $error("not thermometer");
  property p_down;
    agc_enable && agc_lower && gain_code == 3'h6 |=> gain_code == 3'h3;
  endproperty
  a_down: assert property (p_down) else $error("lowering from 110");
  property p_ceil;
    agc_enable && agc_raise && !agc_lower |=> gain_code == $past(gain_code) || gain_code <= gain_ceiling;
  endproperty
  a_ceil: assert property (p_ceil) else $error("gain above ceiling");
  // Divisor held steady around the edge, so a retap cannot fire this
  property p_adck;
    $rose(adc_clk) && $past(divisor, 2) == 2'h0 ##1 divisor == 2'h0 && $stable(divisor) |-> !adc_clk;
  endproperty
  a_adck: assert property (p_adck) else $error("adc not half rate");
  c_agc: cover property (gain_code == 3'h6 ##1 gain_code == 3'h3);
  c_full: cover property (adc_out_valid && adc_out == 8'hE0);
  c_four: cover property (four_bit_mode && adc_out == 8'h0E);
endmodule
`default_nettype wire

// *** test/test_exposure_regs.sv ***
// Self-checking bench for the exposure register bank and its serial slave.
// Assumes a 50 MHz crystal clock and a pulled-up data wire.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_exposure_regs;
  logic sys_clk, reset_n, scl_in, sda_out, sda_oe_n, m_sda, address_select_0, address_select_1, agc_enable;
  logic agc_lower, agc_raise, comparator_enable, four_bit_mode, adc_valid, adc_out_valid, adc_clk, pixel_clk;
  logic forced_average_load;
  logic [1:0] divisor;
  logic [2:0] gain_code, gain_ceiling;
  logic [7:0] adc_data, adc_out, threshold_low, threshold_mid, threshold_high, forced_frame_average, compare_threshold;
  logic [13:0] gain_value_milli;
  logic [8:0] rx;
  wire logic sda_in;
  int mismatches, n_checks, loads, cyc;
  localparam logic [13:0] GV [8] = '{14'h03E8, 14'h07D0, 14'h0535, 14'h0FA0, 14'h0477, 14'h0A6B, 14'h0640, 14'h1F40};
  assign sda_in = m_sda & (sda_oe_n | sda_out);
  exposure_regs dut_u (.*);
  two_wire_master m_u (.sys_clk(sys_clk), .sda_in(sda_in), .scl(scl_in), .sda(m_sda));
  always #10 sys_clk = ~sys_clk;
  // Whole run is near 9400 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (forced_average_load === 1'b1) loads++;
    if (cyc == 30000) begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] b);
    m_u.xfer({b, 1'b1}, rx);
    `CHK("ack", 1'b0, rx[0])
  endtask
  task automatic rd(input logic last, input logic [7:0] e);
    m_u.xfer({8'hFF, last}, rx);
    `CHK("rdata", e, rx[8:1])
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d);
    m_u.start();
    send(a);
    send(i);
    send(d);
    m_u.stop();
  endtask
  task automatic step(input logic dn);
    @(posedge sys_clk);
    agc_lower <= dn;
    agc_raise <= !dn;
    @(posedge sys_clk);
    agc_lower <= 1'b0;
    agc_raise <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic adc(input logic cm, input logic fb, input logic [7:0] d, input logic [7:0] e);
    @(posedge sys_clk);
    comparator_enable <= cm;
    four_bit_mode <= fb;
    adc_valid <= 1'b1;
    adc_data <= d;
    @(posedge sys_clk);
    adc_valid <= 1'b0;
    @(negedge sys_clk);
    `CHK("adc", e, adc_out)
  endtask
  // Start phase unknown, so the first rise only opens the window
  task automatic per(input logic pix, output int p);
    logic q, v;
    int r;
    r = 0;
    p = 0;
    q = 1'b1;
    repeat (300) begin
      @(negedge sys_clk);
      v = pix ? pixel_clk : adc_clk;
      if (v && !q) r++;
      if (r == 1) p++;
      q = v;
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    `CHK("div", 2'h0, divisor)
    `CHK("ceil", 3'h7, gain_ceiling)
    `CHK("thr", 24'h55_6473, {threshold_low, threshold_mid, threshold_high})
    `CHK("avg", 8'h00, forced_frame_average)
    `CHK("cthr", 8'h80, compare_threshold)
  endtask
  task automatic t_multi();
    m_u.start();
    send(8'h20);
    send(8'hA7);
    send(8'h11);
    send(8'h22);
    send(8'h33);
    m_u.stop();
    `CHK("thr", 24'h11_2233, {threshold_low, threshold_mid, threshold_high})
    m_u.start();
    send(8'h20);
    send(8'hA7);
    m_u.start();
    send(8'h21);
    rd(1'b0, 8'h11);
    rd(1'b0, 8'h22);
    rd(1'b1, 8'h33);
    m_u.stop();
  endtask
  task automatic t_same();
    loads = 0;
    m_u.start();
    send(8'h20);
    send(8'h73);
    send(8'h5A);
    send(8'hA5);
    m_u.stop();
    `CHK("avg", 8'hA5, forced_frame_average)
    `CHK("loads", 2, loads)
    m_u.start();
    send(8'h21);
    rd(1'b0, 8'hA5);
    rd(1'b1, 8'hA5);
    m_u.stop();
  endtask
  task automatic t_gain();
    m_u.start();
    send(8'h20);
    send(8'h24);
    for (int c = 0; c < 8; c++) begin
      send(8'(c));
      @(negedge sys_clk);
      `CHK("gval", GV[c], gain_value_milli)
    end
    m_u.stop();
    wreg(8'h20, 8'h24, 8'h06);
    agc_enable <= 1'b1;
    step(1'b1);
    `CHK("agc", 3'h3, gain_code)
    wreg(8'h20, 8'h26, 8'h03);
    step(1'b0);
    `CHK("agc", 3'h3, gain_code)
    step(1'b1);
    `CHK("agc", 3'h1, gain_code)
  endtask
  task automatic t_addr();
    @(posedge sys_clk);
    {address_select_1, address_select_0} <= 2'b11;
    m_u.start();
    m_u.xfer(9'h049, rx);
    `CHK("nak", 1'b1, rx[0])
    m_u.stop();
    wreg(8'h26, 8'h29, 8'h77);
    `CHK("thrh", 8'h77, threshold_high)
    {address_select_1, address_select_0} <= 2'b00;
  endtask
  task automatic t_adc();
    adc(1'b0, 1'b0, 8'h9C, 8'h9C);
    adc(1'b1, 1'b0, 8'h80, 8'hE0);
    adc(1'b1, 1'b0, 8'h7F, 8'h10);
    wreg(8'h20, 8'h75, 8'hA0);
    adc(1'b1, 1'b1, 8'h0A, 8'h0E);
    adc(1'b1, 1'b1, 8'h09, 8'h01);
    adc(1'b0, 1'b0, 8'h55, 8'h55);
  endtask
  task automatic t_clk();
    int p;
    for (int n = 0; n < 4; n++) begin
      wreg(8'h20, 8'h25, 8'(n));
      per(1'b0, p);
      `CHK("adcp", 2 << n, p)
      per(1'b1, p);
      `CHK("pixp", 16 << n, p)
    end
    @(posedge sys_clk);
    four_bit_mode <= 1'b1;
    per(1'b1, p);
    `CHK("pixp", 64, p)
  endtask
  initial begin
    {sys_clk, reset_n, agc_enable, agc_lower, agc_raise, comparator_enable, four_bit_mode, adc_valid} = '0;
    {address_select_0, address_select_1, adc_data} = '0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_multi();
    t_same();
    t_gain();
    t_addr();
    t_adc();
    t_clk();
    close_out();
  end
endmodule
bind exposure_regs exposure_regs_asserts chk_u (.*);
`default_nettype wire

// *** test/two_wire_master.sv ***
// Behavioural two-wire bus master for the serial slave.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module two_wire_master (
  input wire logic sys_clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  ////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Also a repeated start from scl low
  task automatic start();
    w(3);
    sda <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(4);
    sda <= 1'b0;
    w(4);
    scl <= 1'b0;
  endtask
  // Data moves only with scl low; bit 0 is the ack slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      w(3);
      sda <= tx[i];
      w(4);
      scl <= 1'b1;
      w(3);
      rx[i] = sda_in;
      w(3);
      scl <= 1'b0;
    end
  endtask
  task automatic stop();
    w(3);
    sda <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(4);
    sda <= 1'b1;
    w(6);
  endtask
endmodule
`default_nettype wire
